// ==== verilog/dpeh_consts.svh ====
// register offsets, field positions, reset values and error indices of the error handler
`ifndef DPEH_CONSTS_SVH
`define DPEH_CONSTS_SVH
// register byte offsets
`define DPEH_OFS_PCTL  8'h00
`define DPEH_OFS_DCTL  8'h04
`define DPEH_OFS_BCTL  8'h08
`define DPEH_OFS_SSTAT 8'h0c
`define DPEH_OFS_USTAT 8'h10
`define DPEH_OFS_UMASK 8'h14
`define DPEH_OFS_USEV  8'h18
`define DPEH_OFS_PTR   8'h1c
`define DPEH_OFS_HLOG1 8'h20
`define DPEH_OFS_HLOG2 8'h24
`define DPEH_OFS_HLOG3 8'h28
`define DPEH_OFS_HLOG4 8'h2c
// field positions
`define DPEH_BIT_SYSEN   0
`define DPEH_BIT_SSERR   1
`define DPEH_BIT_FTLEN   0
`define DPEH_BIT_NFTLEN  1
`define DPEH_BIT_FTLDTD  2
`define DPEH_BIT_NFTLDTD 3
`define DPEH_BIT_SPERESP 0
`define DPEH_BIT_BSERREN 1
`define DPEH_BIT_MAMODE  2
`define DPEH_BIT_PTRVLD  2
// error indices, also bit positions in status, mask and severity
`define DPEH_ERR_PERR 0
`define DPEH_ERR_SERR 1
`define DPEH_ERR_MA   2
`define DPEH_ERR_TA   3
// reset values
`define DPEH_RST_MASK 4'h0
`define DPEH_RST_SEV  4'h0
`endif

// ==== verilog/dpeh_pkg.sv ====
// types of the downstream error handler
package dpeh_pkg;
  typedef enum logic [1:0] {
    DPEH_CPL_SC,
    DPEH_CPL_UR,
    DPEH_CPL_CA
  } dpeh_cpl_status_type;
  typedef struct packed {
    logic         active;
    logic         posted;
    logic         write;
    logic         poisoned;
    logic [127:0] header;
  } dpeh_txn_type;
  typedef struct packed {
    logic immData;
    logic masterAbort;
    logic targetAbort;
  } dpeh_term_type;
  typedef struct packed {
    logic                valid;
    dpeh_cpl_status_type status;
  } dpeh_cpl_type;
  typedef struct packed {
    logic valid;
    logic fatal;
  } dpeh_msg_type;
  typedef struct packed {
    logic             perrMeta;
    logic             perrSync;
    logic             perrLast;
    logic             serrMeta;
    logic             serrSync;
    logic             serrLast;
    logic             perrPending;
    logic [1:0]       primaryStatus;
    logic [3:0]       deviceStatus;
    logic [2:0]       bridgeControl;
    logic             masterDataParityFlag;
    logic             receivedSystemErrorFlag;
    logic             receivedMasterAbortFlag;
    logic             receivedTargetAbortFlag;
    logic [3:0]       uncStatus;
    logic [3:0]       uncMask;
    logic [3:0]       uncSeverity;
    logic [1:0]       firstErrorPointer;
    logic             pointerValid;
    logic [3:0][31:0] headerLog;
    logic [31:0]      readData;
    dpeh_cpl_type     cpl;
    dpeh_msg_type     msg;
    logic             discard;
  } dpeh_state_type;
endpackage

// ==== verilog/dpeh_error_handler.sv ====
// downstream error handler: pin sampling, error registers, logging and reporting
`timescale 1ns/100ps
`include "dpeh_consts.svh"

module dpeh_error_handler (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // register port
  input  wire logic [7:0]             busAddr,
  input  wire logic [31:0]            busWriteData,
  input  wire logic                   busWrite,
  input  wire logic                   busRead,
  output logic [31:0]                 busReadData,
  // secondary bus pins, active low
  input  wire logic                   secondaryParityErrorPinN,
  input  wire logic                   secondarySystemErrorPinN,
  // transaction being forwarded and its termination
  input  wire dpeh_pkg::dpeh_txn_type  txn,
  input  wire dpeh_pkg::dpeh_term_type term,
  // answers toward the primary side
  output dpeh_pkg::dpeh_cpl_type      cpl,
  output dpeh_pkg::dpeh_msg_type      errMsg,
  output logic                        discardTxn
);
  import dpeh_pkg::*;

  dpeh_state_type state;
  dpeh_state_type next_state;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin : nextStateLogic
    logic [3:0] ev;
    logic [3:0] gate;
    logic       perrRise;
    logic       serrRise;
    logic       hit;
    logic       sev;
    logic       send;
    ev = 4'h0;
    gate = 4'h0;
    perrRise = 1'b0;
    serrRise = 1'b0;
    hit = 1'b0;
    sev = 1'b0;
    send = 1'b0;
    next_state = state;

    // pin synchronisers, assertion taken as the low-going edge
    next_state.perrMeta = ~secondaryParityErrorPinN;
    next_state.perrSync = state.perrMeta;
    next_state.perrLast = state.perrSync;
    next_state.serrMeta = ~secondarySystemErrorPinN;
    next_state.serrSync = state.serrMeta;
    next_state.serrLast = state.serrSync;
    perrRise = state.perrSync & ~state.perrLast;
    serrRise = state.serrSync & ~state.serrLast;

    // pulse outputs default low
    next_state.cpl.valid = 1'b0;
    next_state.cpl.status = DPEH_CPL_SC;
    next_state.msg.valid = 1'b0;
    next_state.msg.fatal = 1'b0;
    next_state.discard = 1'b0;
    next_state.readData = 32'h0;

    // ----------------------------------------------------------------
    // software writes, clears applied before hardware sets
    // ----------------------------------------------------------------
    if (busWrite) begin
      case (busAddr)
        `DPEH_OFS_PCTL: begin
          next_state.primaryStatus[`DPEH_BIT_SYSEN] = busWriteData[`DPEH_BIT_SYSEN];
          if (busWriteData[`DPEH_BIT_SSERR]) begin
            next_state.primaryStatus[`DPEH_BIT_SSERR] = 1'b0;
          end
        end
        `DPEH_OFS_DCTL: begin
          next_state.deviceStatus[`DPEH_BIT_FTLEN] = busWriteData[`DPEH_BIT_FTLEN];
          next_state.deviceStatus[`DPEH_BIT_NFTLEN] = busWriteData[`DPEH_BIT_NFTLEN];
          if (busWriteData[`DPEH_BIT_FTLDTD]) begin
            next_state.deviceStatus[`DPEH_BIT_FTLDTD] = 1'b0;
          end
          if (busWriteData[`DPEH_BIT_NFTLDTD]) begin
            next_state.deviceStatus[`DPEH_BIT_NFTLDTD] = 1'b0;
          end
        end
        `DPEH_OFS_BCTL: begin
          next_state.bridgeControl = busWriteData[2:0];
        end
        `DPEH_OFS_SSTAT: begin
          if (busWriteData[`DPEH_ERR_PERR]) begin
            next_state.masterDataParityFlag = 1'b0;
          end
          if (busWriteData[`DPEH_ERR_SERR]) begin
            next_state.receivedSystemErrorFlag = 1'b0;
          end
          if (busWriteData[`DPEH_ERR_MA]) begin
            next_state.receivedMasterAbortFlag = 1'b0;
          end
          if (busWriteData[`DPEH_ERR_TA]) begin
            next_state.receivedTargetAbortFlag = 1'b0;
          end
        end
        `DPEH_OFS_USTAT: begin
          next_state.uncStatus = state.uncStatus & ~busWriteData[3:0];
        end
        `DPEH_OFS_UMASK: begin
          next_state.uncMask = busWriteData[3:0];
        end
        `DPEH_OFS_USEV: begin
          next_state.uncSeverity = busWriteData[3:0];
        end
        `DPEH_OFS_PTR: begin
          if (busWriteData[`DPEH_BIT_PTRVLD]) begin
            next_state.pointerValid = 1'b0;
          end
        end
        default: begin
          next_state.readData = 32'h0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // software reads, data stands in the following cycle only
    // ----------------------------------------------------------------
    if (busRead) begin
      case (busAddr)
        `DPEH_OFS_PCTL: begin
          next_state.readData = {30'h0, state.primaryStatus};
        end
        `DPEH_OFS_DCTL: begin
          next_state.readData = {28'h0, state.deviceStatus};
        end
        `DPEH_OFS_BCTL: begin
          next_state.readData = {29'h0, state.bridgeControl};
        end
        `DPEH_OFS_SSTAT: begin
          next_state.readData = {28'h0, state.receivedTargetAbortFlag,
                                 state.receivedMasterAbortFlag,
                                 state.receivedSystemErrorFlag,
                                 state.masterDataParityFlag};
        end
        `DPEH_OFS_USTAT: begin
          next_state.readData = {28'h0, state.uncStatus};
        end
        `DPEH_OFS_UMASK: begin
          next_state.readData = {28'h0, state.uncMask};
        end
        `DPEH_OFS_USEV: begin
          next_state.readData = {28'h0, state.uncSeverity};
        end
        `DPEH_OFS_PTR: begin
          next_state.readData = {29'h0, state.pointerValid, state.firstErrorPointer};
        end
        `DPEH_OFS_HLOG1: begin
          next_state.readData = state.headerLog[0];
        end
        `DPEH_OFS_HLOG2: begin
          next_state.readData = state.headerLog[1];
        end
        `DPEH_OFS_HLOG3: begin
          next_state.readData = state.headerLog[2];
        end
        `DPEH_OFS_HLOG4: begin
          next_state.readData = state.headerLog[3];
        end
        default: begin
          next_state.readData = 32'h0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // error events
    // ----------------------------------------------------------------
    // parity only counts on non-poisoned writes being forwarded
    ev[`DPEH_ERR_PERR] = perrRise & txn.active & txn.write & ~txn.poisoned;
    ev[`DPEH_ERR_SERR] = serrRise & txn.active;
    ev[`DPEH_ERR_MA] = term.masterAbort & txn.active;
    ev[`DPEH_ERR_TA] = term.targetAbort & txn.active;

    // message gates per error
    gate[`DPEH_ERR_PERR] = ~state.uncMask[`DPEH_ERR_PERR];
    gate[`DPEH_ERR_SERR] = ~state.uncMask[`DPEH_ERR_SERR] |
                           state.bridgeControl[`DPEH_BIT_BSERREN];
    gate[`DPEH_ERR_MA] = ~state.uncMask[`DPEH_ERR_MA] |
                         (txn.posted & state.bridgeControl[`DPEH_BIT_MAMODE]);
    gate[`DPEH_ERR_TA] = ~state.uncMask[`DPEH_ERR_TA];

    // status bits, hardware set wins over a clear in the same cycle
    if (ev[`DPEH_ERR_PERR]) begin
      next_state.uncStatus[`DPEH_ERR_PERR] = 1'b1;
      if (state.bridgeControl[`DPEH_BIT_SPERESP]) begin
        next_state.masterDataParityFlag = 1'b1;
      end
    end
    if (ev[`DPEH_ERR_SERR]) begin
      next_state.receivedSystemErrorFlag = 1'b1;
      next_state.uncStatus[`DPEH_ERR_SERR] = 1'b1;
    end
    if (ev[`DPEH_ERR_MA]) begin
      next_state.receivedMasterAbortFlag = 1'b1;
      next_state.uncStatus[`DPEH_ERR_MA] = 1'b1;
    end
    if (ev[`DPEH_ERR_TA]) begin
      next_state.receivedTargetAbortFlag = 1'b1;
      next_state.uncStatus[`DPEH_ERR_TA] = 1'b1;
    end

    // ----------------------------------------------------------------
    // detection flags and upstream messages
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      if (ev[i]) begin
        sev = state.uncSeverity[i];
        if (sev) begin
          next_state.deviceStatus[`DPEH_BIT_FTLDTD] = 1'b1;
        end else begin
          next_state.deviceStatus[`DPEH_BIT_NFTLDTD] = 1'b1;
        end
        send = gate[i] & (state.primaryStatus[`DPEH_BIT_SYSEN] |
               (sev ? state.deviceStatus[`DPEH_BIT_FTLEN]
                    : state.deviceStatus[`DPEH_BIT_NFTLEN]));
        if (send) begin
          next_state.msg.valid = 1'b1;
          // one message per cycle; fatal wins when errors coincide
          next_state.msg.fatal = next_state.msg.fatal | sev;
          if (state.primaryStatus[`DPEH_BIT_SYSEN]) begin
            next_state.primaryStatus[`DPEH_BIT_SSERR] = 1'b1;
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // first error pointer and header log, lowest index first
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      if (!hit && ev[i] && !state.uncMask[i] && !state.pointerValid) begin
        hit = 1'b1;
        next_state.firstErrorPointer = 2'(i);
        next_state.pointerValid = 1'b1;
        if (i == `DPEH_ERR_MA && !txn.posted) begin
          next_state.headerLog[3] = txn.header[31:0];
        end else if (i != `DPEH_ERR_SERR) begin
          next_state.headerLog = txn.header;
        end
      end
    end

    // ----------------------------------------------------------------
    // completions and discards
    // ----------------------------------------------------------------
    // the parity event may come cycles before the data completion, so it is held
    // until the write completes or stops being forwarded
    if (ev[`DPEH_ERR_PERR] && !txn.posted) begin
      next_state.perrPending = 1'b1;
    end
    if (!txn.active) begin
      next_state.perrPending = 1'b0;
    end
    // parity and system error never raise a discard, forwarding goes on
    if (txn.active && txn.posted) begin
      if (term.masterAbort || term.targetAbort) begin
        next_state.discard = 1'b1;
      end
    end
    // posted parity error only sets status and reports
    if (txn.active && !txn.posted) begin
      if (term.masterAbort) begin
        next_state.cpl.valid = 1'b1;
        next_state.cpl.status = DPEH_CPL_UR;
        next_state.perrPending = 1'b0;
      end else if (term.targetAbort) begin
        next_state.cpl.valid = 1'b1;
        next_state.cpl.status = DPEH_CPL_CA;
        next_state.perrPending = 1'b0;
      end else if (term.immData) begin
        next_state.cpl.valid = 1'b1;
        if (state.perrPending || ev[`DPEH_ERR_PERR]) begin
          next_state.cpl.status = DPEH_CPL_UR;
        end
        next_state.perrPending = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
      state.uncMask <= `DPEH_RST_MASK;
      state.uncSeverity <= `DPEH_RST_SEV;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busReadData = state.readData;
  assign cpl = state.cpl;
  assign errMsg = state.msg;
  assign discardTxn = state.discard;

endmodule // dpeh_error_handler

// ==== verification/dpeh_error_handler_chk.sv ====
// port checks of the downstream error handler
`timescale 1ns/100ps
module dpeh_error_handler_chk (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    reset,
  // register port
  input wire logic [7:0]              busAddr,
  input wire logic [31:0]             busWriteData,
  input wire logic                    busWrite,
  input wire logic                    busRead,
  input wire logic [31:0]             busReadData,
  // secondary pins and forwarded transaction
  input wire logic                    secondaryParityErrorPinN,
  input wire logic                    secondarySystemErrorPinN,
  input wire dpeh_pkg::dpeh_txn_type  txn,
  input wire dpeh_pkg::dpeh_term_type term,
  // answers toward the primary side
  input wire dpeh_pkg::dpeh_cpl_type  cpl,
  input wire dpeh_pkg::dpeh_msg_type  errMsg,
  input wire logic                    discardTxn
);
  import dpeh_pkg::*;
  logic [3:0] perrAge;
  // --------
  // cycles since the parity pin fell inside the current transaction
  // --------
  always_ff @(posedge clk) begin
    if (reset || !txn.active) begin
      perrAge <= 4'h0;
    end else if (perrAge != 4'h0) begin
      perrAge <= (perrAge == 4'hf) ? perrAge : perrAge + 4'h1;
    end else if (!secondaryParityErrorPinN) begin
      perrAge <= 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence npWriteImm;
    txn.active && !txn.posted && txn.write && !txn.poisoned && term.immData
      && !term.masterAbort && !term.targetAbort;
  endsequence
  sequence maSeen;
    txn.active && term.masterAbort && !term.targetAbort && !term.immData;
  endsequence
  sequence taSeen;
    txn.active && term.targetAbort && !term.masterAbort && !term.immData;
  endsequence
  perr_ur_cpl_a: assert property (
    npWriteImm ##0 (perrAge == 4'h0 || perrAge > 4'h5) |=> cpl.valid
      && cpl.status == (($past(perrAge) == 4'h0) ? DPEH_CPL_SC : DPEH_CPL_UR))
    else $error("write completion status wrong after parity pin");
  ma_posted_discard_a: assert property (
    maSeen ##0 txn.posted |=> discardTxn && !cpl.valid)
    else $error("posted master abort not discarded");
  ta_posted_drop_a: assert property (
    taSeen ##0 txn.posted |=> discardTxn && !cpl.valid)
    else $error("posted target abort not dropped");
  ma_nonposted_ur_a: assert property (
    maSeen ##0 !txn.posted |=> cpl.valid && cpl.status == DPEH_CPL_UR && !discardTxn)
    else $error("non-posted master abort without UR completion");
  ta_nonposted_ca_a: assert property (
    taSeen ##0 !txn.posted |=> cpl.valid && cpl.status == DPEH_CPL_CA && !discardTxn)
    else $error("non-posted target abort without CA completion");
  discard_cause_a: assert property (
    discardTxn |-> $past(txn.posted) && ($past(term.masterAbort) || $past(term.targetAbort)))
    else $error("discard without a posted abort");
  idle_quiet_a: assert property (
    !txn.active |=> !cpl.valid && !errMsg.valid && !discardTxn)
    else $error("answer without a forwarded transaction");
  discard_pulse_a: assert property (
    discardTxn && !term.masterAbort && !term.targetAbort |=> !discardTxn)
    else $error("discard pulse longer than one cycle");
endmodule // dpeh_error_handler_chk

bind dpeh_error_handler dpeh_error_handler_chk chk (
  .clk(clk), .reset(reset), .busAddr(busAddr), .busWriteData(busWriteData),
  .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData),
  .secondaryParityErrorPinN(secondaryParityErrorPinN),
  .secondarySystemErrorPinN(secondarySystemErrorPinN), .txn(txn), .term(term),
  .cpl(cpl), .errMsg(errMsg), .discardTxn(discardTxn)
);

// ==== verification/dpeh_pci_target.sv ====
// behavioural secondary-bus target: terminations and active-low error pins
`timescale 1ns/100ps
module dpeh_pci_target (
  // clock and command from the bench
  input wire logic                   clk,
  input wire logic                   go,
  input wire logic [1:0]             kind,
  input wire logic [1:0]             delay,
  input wire dpeh_pkg::dpeh_txn_type txn,
  // toward the bridge
  output dpeh_pkg::dpeh_term_type    term,
  output logic                       parityPinN,
  output logic                       systemPinN
);
  import dpeh_pkg::*;
  // one process drives every output; released pins sit at their pull-up level
  initial begin
    term = '0;
    parityPinN = 1'h1;
    systemPinN = 1'h1;
    forever begin
      @(posedge clk);
      if (go) begin
        repeat (delay) @(posedge clk);
        case (kind)
          2'h0: begin
            parityPinN <= 1'h0;
            repeat (2) @(posedge clk);
            parityPinN <= 1'h1;
            repeat (6) @(posedge clk);
            // only a non-posted target completes with data
            if (!txn.posted) begin
              term.immData <= 1'h1;
              @(posedge clk);
              term.immData <= 1'h0;
            end
          end
          2'h1: begin
            systemPinN <= 1'h0;
            repeat (2) @(posedge clk);
            systemPinN <= 1'h1;
          end
          2'h2: begin
            term.masterAbort <= 1'h1;
            @(posedge clk);
            term.masterAbort <= 1'h0;
          end
          default: begin
            term.targetAbort <= 1'h1;
            @(posedge clk);
            term.targetAbort <= 1'h0;
          end
        endcase
      end
    end
  end
endmodule // dpeh_pci_target

// ==== verification/tb_downstream_pci_error_handler.sv ====
// self-checking bench of the downstream error handler
`timescale 1ns/100ps
module tb_downstream_pci_error_handler;
  import dpeh_pkg::*;
  logic          clk = 1'h0;
  logic          reset = 1'h1;
  logic [7:0]    busAddr = 8'h0;
  logic [31:0]   busWriteData = 32'h0;
  logic          busWrite = 1'h0;
  logic          busRead = 1'h0;
  logic [31:0]   busReadData;
  logic          parPinN;
  logic          sysPinN;
  dpeh_txn_type  txn = '0;
  dpeh_term_type term;
  dpeh_cpl_type  cpl;
  dpeh_msg_type  errMsg;
  logic          discardTxn;
  logic          go = 1'h0;
  logic [1:0]    kind = 2'h0;
  logic [1:0]    delay = 2'h0;
  int            n_fail = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  int            nDisc;
  // reference model
  logic          sysEn, sserr, fen, nen, fdet, ndet, pvld;
  logic [2:0]    bctl;
  logic [3:0]    sstat, ustat, mask, sev;
  logic [1:0]    ptr;
  logic [31:0]   hlog [4];
  logic [1:0]    cplQ [$];
  logic          msgQ [$];
  always #12.5 clk = ~clk;
  dpeh_error_handler dut (
    .clk(clk), .reset(reset), .busAddr(busAddr), .busWriteData(busWriteData),
    .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData),
    .secondaryParityErrorPinN(parPinN), .secondarySystemErrorPinN(sysPinN),
    .txn(txn), .term(term), .cpl(cpl), .errMsg(errMsg), .discardTxn(discardTxn));
  dpeh_pci_target target (
    .clk(clk), .go(go), .kind(kind), .delay(delay), .txn(txn), .term(term),
    .parityPinN(parPinN), .systemPinN(sysPinN));
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // collects one-cycle answers; cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cpl.valid === 1'h1) cplQ.push_back(cpl.status);
    if (errMsg.valid === 1'h1) msgQ.push_back(errMsg.fatal);
    if (discardTxn === 1'h1) nDisc++;
    if (cycles == 12000) begin
      n_fail++;
      results();
    end
  end
  task automatic chkOut(string what, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [31:0] mreg(logic [7:0] a);
    case (a)
      8'h00: return {30'h0, sserr, sysEn};
      8'h04: return {28'h0, ndet, fdet, nen, fen};
      8'h08: return {29'h0, bctl};
      8'h0c: return {28'h0, sstat};
      8'h10: return {28'h0, ustat};
      8'h14: return {28'h0, mask};
      8'h18: return {28'h0, sev};
      8'h1c: return {29'h0, pvld, ptr};
      8'h20, 8'h24, 8'h28, 8'h2c: return hlog[a[3:2]];
      default: return 32'h0;
    endcase
  endfunction
  task automatic mreset();
    {sysEn, sserr, fen, nen, fdet, ndet, pvld, bctl, sstat, ustat, mask, sev, ptr} = '0;
    hlog = '{default: 32'h0};
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    busWrite <= 1'h1;
    busAddr <= a;
    busWriteData <= d;
    @(posedge clk);
    busWrite <= 1'h0;
    case (a)
      8'h00: {sserr, sysEn} = {sserr & ~d[1], d[0]};
      8'h04: {ndet, fdet, nen, fen} = {ndet & ~d[3], fdet & ~d[2], d[1:0]};
      8'h08: bctl = d[2:0];
      8'h0c: sstat &= ~d[3:0];
      8'h10: ustat &= ~d[3:0];
      8'h14: mask = d[3:0];
      8'h18: sev = d[3:0];
      8'h1c: pvld &= ~d[2];
      default: ;
    endcase
  endtask
  task automatic checkAll();
    logic [31:0] e;
    for (int a = 0; a <= 'h30; a += 4) begin
      e = mreg(8'(a));
      @(posedge clk);
      busRead <= 1'h1;
      busAddr <= 8'(a);
      @(posedge clk);
      busRead <= 1'h0;
      @(negedge clk);
      chkOut($sformatf("register %h", a), e, busReadData);
    end
  endtask
  task automatic clr();
    wr(8'h00, {30'h0, 1'h1, sysEn});
    wr(8'h04, {28'h0, 2'h3, nen, fen});
    wr(8'h0c, 32'hf);
    wr(8'h10, 32'hf);
    wr(8'h1c, 32'h4);
  endtask
  // kind: 0 parity pin, 1 system error pin, 2 master abort, 3 target abort
  task automatic run(logic [1:0] k, logic p, logic w, logic poi, logic act);
    logic [127:0] h;
    logic hit, send;
    int nc;
    dpeh_cpl_status_type st;
    h = {$urandom, $urandom, $urandom, $urandom};
    hit = act && (k != 2'h0 || (w && !poi));
    nc = (!p && k != 2'h1 && act) ? 1 : 0;
    st = (k == 2'h3) ? DPEH_CPL_CA : ((k == 2'h2 || hit) ? DPEH_CPL_UR : DPEH_CPL_SC);
    send = 1'h0;
    if (hit) begin
      sstat[k] = sstat[k] | (k != 2'h0) | bctl[0];
      ustat[k] = 1'h1;
      if (!mask[k] && !pvld) begin
        ptr = k;
        pvld = 1'h1;
        for (int i = 0; i < 4; i++) begin
          if (k != 2'h1 && !(k == 2'h2 && !p)) hlog[i] = h[32*i +: 32];
        end
        if (k == 2'h2 && !p) hlog[3] = h[31:0];
      end
      send = (!mask[k] || (k == 2'h1 && bctl[1]) || (k == 2'h2 && p && bctl[2]))
             && (sysEn || (sev[k] ? fen : nen));
      sserr |= send && sysEn;
      fdet |= sev[k];
      ndet |= !sev[k];
    end
    @(posedge clk);
    txn <= '{act, p, w, poi, h};
    kind <= k;
    delay <= 2'($urandom_range(0, 3));
    go <= 1'h1;
    cplQ.delete();
    msgQ.delete();
    nDisc = 0;
    @(posedge clk);
    go <= 1'h0;
    repeat (20) @(posedge clk);
    txn.active <= 1'h0;
    repeat (2) @(posedge clk);
    chkOut("message count", 32'(send), 32'(msgQ.size()));
    if (send) chkOut("message severity", 32'(sev[k]), 32'(msgQ[0]));
    chkOut("completion count", 32'(nc), 32'(cplQ.size()));
    if (nc != 0) chkOut("completion status", 32'(st), 32'(cplQ[0]));
    chkOut("discard count", 32'(hit && p && k[1]), 32'(nDisc));
    checkAll();
  endtask
  initial begin
    logic [31:0] r;
    void'($urandom(62));
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    mreset();
    wr(8'h20, 32'hffffffff);
    wr(8'h34, 32'hffffffff);
    checkAll();
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h7);
      wr(8'h14, 32'h0);
      wr(8'h18, k[2] ? 32'hf : 32'h0);
      run(2'(k), k[2], 1'h1, 1'h0, 1'h1);
      clr();
    end
    $display("test each error done");
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      wr(8'h00, {30'h0, r[1:0]});
      wr(8'h04, {28'h0, r[5:2]});
      wr(8'h08, {29'h0, r[8:6]});
      wr(8'h14, {28'h0, r[12:9]});
      wr(8'h18, {28'h0, r[16:13]});
      run(r[18:17], r[19], r[19] | r[20], r[23:21] == 3'h0, r[26:24] != 3'h0);
      if (r[28:27] == 2'h0) clr();
    end
    $display("test random errors done");
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    mreset();
    checkAll();
    $display("test second reset done");
    results();
  end
endmodule // tb_downstream_pci_error_handler
